// ==== pe_glue_pkg.sv ====
// Purpose: Shared constants for the pixel engine and its host bus glue
// Assumes: One clock, clk_sys at 25 MHz, synchronous active-high reset
// Notes: APB offsets are byte addresses of aligned 32-bit words
// How it works
// (R1) Granularity bit: 0 by plane, 1 by pixel
// (R2) Plane read: only one plane active drives
// (R3) Plane write: several planes may be active
// (R4) Pixel transfer: any planes, step sets packing
// (R5) Pixel buffers enabled only in pixel mode
// (R6) Buffer enables from drive enable and mode
// (R7) Software matches mode flag to next transfer
// (R8) One address sets, another clears mode
// (R9) Mode addresses always answered, never stall
// (R10) Direction from write line, inverted under acknowledge
// (R11) Nine maskable engine interrupt sources
// (R12) Signal and enabled pick share one bit
// (R13) Acknowledge cycle: code 7, upper nibble F
// (R14) Autovector and select never together, no acknowledge
// (R15) Active-low level held two clocks minimum
// (R16) Autovector answers; engine not told of cycle
// (R17) No vector register; external select offered
// (R18) Acknowledge write clears named bits, drops output
// (R19) Bits set meanwhile survive the acknowledge write
// (R20) Service routine reads status, then acknowledges
// (R21) Acknowledge without pending cause gives bus error
// (R22) Mode flag resets to by plane
package pe_glue_pkg;
  localparam logic [7:0] OFS_MODE_SET = 8'h00;
  localparam logic [7:0] OFS_MODE_CLR = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_ENG_STATUS = 8'h0C;
  localparam logic [7:0] OFS_ENG_MASK = 8'h10;
  localparam logic [7:0] OFS_ENG_ACK = 8'h14;
  localparam int ST_MODE = 0;
  localparam int ST_IRQ = 1;
  localparam int ST_SPUR = 2;
  localparam int ST_MISMATCH = 3;
  localparam logic MODE_RESET = 1'b0;
  localparam logic GRAN_PLANE = 1'b0;
  localparam logic GRAN_PIXEL = 1'b1;
  localparam int INT_W = 9;
  localparam int INT_SIGPICK = 8;
  localparam logic [INT_W-1:0] MASK_RESET = 9'h000;
  localparam logic [2:0] IACK_FC = 3'h7;
  localparam logic [3:0] IACK_CODE = 4'hF;
  localparam logic SEL_MASK = 1'b0;
  localparam logic SEL_ACK = 1'b1;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    IK_IDLE = 2'b00,
    IK_AVEC = 2'b01,
    IK_BERR = 2'b11,
    IK_SEL = 2'b10
  } iack_st_t;
endpackage

// ==== pe_link_if.sv ====
// Purpose: Link between pixel engine and host bus glue
// Assumes: Both ends on clk_sys
// Notes: Engine drives status, irq and drive enable from flops
`timescale 1ns/10ps
interface pe_link_if;
  import pe_glue_pkg::*;
  logic buffer_drive_enable;
  logic granularity;
  logic irq_n;
  logic [INT_W-1:0] eng_status;
  logic eng_wr_stb;
  logic eng_wr_sel;
  logic [INT_W-1:0] eng_wdata;
  modport engine (
    output buffer_drive_enable, granularity, irq_n, eng_status,
    input eng_wr_stb, eng_wr_sel, eng_wdata
  );
  modport glue (
    input buffer_drive_enable, granularity, irq_n, eng_status,
    output eng_wr_stb, eng_wr_sel, eng_wdata
  );
endinterface

// ==== sync2.sv ====
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs asynchronous to clk_sys
// Notes: First stage read only by second stage
`timescale 1ns/10ps
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic [W-1:0] d, // Asynchronous input
  output logic [W-1:0] q // Synchronised output
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_r <= INIT;
      q <= INIT;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ==== pixel_engine_end.sv ====
// Purpose: Engine end: interrupt register, mask, acknowledge, drive enable
// Assumes: Event inputs are on clk_sys
// Notes: No vector register is provided
`timescale 1ns/10ps
module pixel_engine_end
  import pe_glue_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  pe_link_if.engine link, // Link to glue
  input wire logic [INT_W-2:0] int_events, // Idle..vblank event pulses
  input wire logic sw_signal, // Signal instruction event
  input wire logic pick_detect, // Pick detect event
  input wire logic pick_enable, // Picking enabled
  input wire logic xfer_active, // Block transfer in progress
  input wire logic xfer_gran, // Granularity bit of instruction
  input wire logic [3:0] plane_active, // Activity bits of owned planes
  input wire logic [3:0] pixels_per_word_field, // Step field of instruction
  output logic [3:0] cur_step_r // Pixels per word of transfer
);
  logic [INT_W-1:0] flags_r;
  logic [INT_W-1:0] mask_r;
  logic [INT_W-1:0] set_vec;
  logic [INT_W-1:0] clr_vec;
  logic bde_r;
  logic gran_r;
  logic irq_n_r;

  //----------------------------------------
  // Interrupt register
  //----------------------------------------
  always_comb begin
    set_vec = {sw_signal | (pick_detect & pick_enable), int_events}; // [R11] [R12]
    clr_vec = (link.eng_wr_stb && link.eng_wr_sel == SEL_ACK) ? link.eng_wdata : '0;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flags_r <= '0;
    end else begin
      flags_r <= (flags_r & ~clr_vec) | set_vec; // [R18] [R19]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mask_r <= MASK_RESET;
    end else if (link.eng_wr_stb && link.eng_wr_sel == SEL_MASK) begin
      mask_r <= link.eng_wdata; // [R11]
    end
  end

  // Set bits survive the clear, so an unmasked one keeps the output low
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_n_r <= 1'b1;
    end else begin
      irq_n_r <= ~|((((flags_r & ~clr_vec) | set_vec)) & mask_r); // [R18] [R19]
    end
  end

  //----------------------------------------
  // Transfer drive enable
  //----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bde_r <= 1'b0;
      gran_r <= GRAN_PLANE;
      cur_step_r <= 4'h0;
    end else begin
      bde_r <= xfer_active & |plane_active; // [R2] [R3] [R4]
      gran_r <= xfer_gran; // [R1]
      if (xfer_active && xfer_gran == GRAN_PIXEL) begin
        cur_step_r <= pixels_per_word_field; // [R4]
      end
    end
  end

  assign link.buffer_drive_enable = bde_r;
  assign link.granularity = gran_r;
  assign link.irq_n = irq_n_r;
  assign link.eng_status = flags_r;
endmodule

// ==== host_bus_glue.sv ====
// Purpose: Host glue: buffer enables, direction, mode flag, interrupt decode
// Assumes: Host bus pins asynchronous; APB and link on clk_sys
// Notes: Engine is told nothing of acknowledge cycles
`timescale 1ns/10ps
module host_bus_glue
  import pe_glue_pkg::*;
#(
  parameter logic [2:0] ENGINE_LEVEL = 3'h4,
  parameter bit AUTOVEC = 1'b1
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  pe_link_if.glue link, // Link to engine
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  output logic [31:0] prdata, // APB read data
  input wire logic as_n, // Host address strobe, low
  input wire logic [2:0] fc, // Host function code
  input wire logic [3:0] addr_19_16, // Host address 19..16
  input wire logic [2:0] addr_3_1, // Host address 3..1
  input wire logic system_write_line, // Host write line
  input wire logic data_dma_acknowledge, // Data DMA acknowledge, high
  output logic plane_buf_en_r, // By-plane buffer enable
  output logic pixel_buf_en_r, // By-pixel buffer enable
  output logic buf_dir_write_r, // Buffer direction toward display
  output logic [2:0] ipl_n_r, // Interrupt level, low
  output logic avec_n_r, // Autovector request, low
  output logic iack_sel_n_r, // Vector register select, low
  output logic berr_n_r // Bus error, low
);
  logic as_n_s;
  logic [2:0] fc_s;
  logic [3:0] ahi_s;
  logic [2:0] alvl_s;
  logic wr_s;
  logic ack_s;
  logic mode_r;
  logic spur_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic eng_stb_r;
  logic eng_sel_r;
  logic [INT_W-1:0] eng_wdata_r;
  logic acc_start;
  logic acc_done;
  logic mapped;
  logic iack_hit;
  logic spur_set;
  logic [31:0] status_word;
  iack_st_t ik_r;

  //----------------------------------------
  // Pin synchronisers
  //----------------------------------------
  sync2 #(.W(12), .INIT(12'h800)) u_sync_bus (
    .clk_sys(clk_sys),
    .reset(reset),
    .d({as_n, fc, addr_19_16, addr_3_1, system_write_line}),
    .q({as_n_s, fc_s, ahi_s, alvl_s, wr_s})
  );
  sync2 #(.W(1), .INIT(1'b0)) u_sync_ack (
    .clk_sys(clk_sys),
    .reset(reset),
    .d(data_dma_acknowledge),
    .q(ack_s)
  );

  //----------------------------------------
  // APB slave
  //----------------------------------------
  always_comb begin
    acc_start = psel & penable & ~pready_r;
    acc_done = psel & penable & pready_r;
    mapped = (paddr == OFS_MODE_SET) || (paddr == OFS_MODE_CLR) ||
             (paddr == OFS_STATUS) || (paddr == OFS_ENG_STATUS) ||
             (paddr == OFS_ENG_MASK) || (paddr == OFS_ENG_ACK);
    status_word = 32'h0000_0000;
    status_word[ST_MODE] = mode_r;
    status_word[ST_IRQ] = ~link.irq_n;
    status_word[ST_SPUR] = spur_r;
    status_word[ST_MISMATCH] = link.buffer_drive_enable & (link.granularity != mode_r);
  end

  // Every mapped or unmapped access completes after one wait state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= acc_start; // [R9]
      pslverr_r <= acc_start & ~mapped;
      if (acc_start && !pwrite) begin
        case (paddr)
          OFS_STATUS: prdata_r <= status_word;
          OFS_ENG_STATUS: prdata_r <= {{(32-INT_W){1'b0}}, link.eng_status}; // [R20]
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Any access to set or clear address moves the flag
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_r <= MODE_RESET; // [R22]
    end else if (acc_done && paddr == OFS_MODE_SET) begin
      mode_r <= GRAN_PIXEL; // [R8] [R7]
    end else if (acc_done && paddr == OFS_MODE_CLR) begin
      mode_r <= GRAN_PLANE; // [R8]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      eng_stb_r <= 1'b0;
      eng_sel_r <= SEL_MASK;
      eng_wdata_r <= '0;
    end else begin
      eng_stb_r <= acc_done & pwrite & ((paddr == OFS_ENG_MASK) || (paddr == OFS_ENG_ACK));
      eng_sel_r <= (paddr == OFS_ENG_ACK) ? SEL_ACK : SEL_MASK;
      eng_wdata_r <= pwdata[INT_W-1:0]; // [R18] [R20]
    end
  end

  // Spurious flag: set wins over write-one clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      spur_r <= 1'b0;
    end else if (spur_set) begin
      spur_r <= 1'b1;
    end else if (acc_done && pwrite && paddr == OFS_STATUS && pwdata[ST_SPUR]) begin
      spur_r <= 1'b0;
    end
  end

  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign prdata = prdata_r;
  assign link.eng_wr_stb = eng_stb_r;
  assign link.eng_wr_sel = eng_sel_r;
  assign link.eng_wdata = eng_wdata_r;

  //----------------------------------------
  // Buffer enables and direction
  //----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      plane_buf_en_r <= 1'b0;
      pixel_buf_en_r <= 1'b0;
      buf_dir_write_r <= 1'b0;
    end else begin
      plane_buf_en_r <= link.buffer_drive_enable & (mode_r == GRAN_PLANE); // [R6] [R1]
      pixel_buf_en_r <= link.buffer_drive_enable & (mode_r == GRAN_PIXEL); // [R5] [R6]
      buf_dir_write_r <= wr_s ^ ack_s; // [R10]
    end
  end

  //----------------------------------------
  // Interrupt level
  //----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ipl_n_r <= 3'h7;
    end else begin
      ipl_n_r <= link.irq_n ? 3'h7 : ~ENGINE_LEVEL; // [R15]
    end
  end

  //----------------------------------------
  // Acknowledge cycle decode
  //----------------------------------------
  always_comb begin
    iack_hit = ~as_n_s && fc_s == IACK_FC && ahi_s == IACK_CODE &&
               alvl_s == ENGINE_LEVEL; // [R13]
    spur_set = (ik_r == IK_IDLE) && iack_hit && link.irq_n; // [R21]
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ik_r <= IK_IDLE;
      avec_n_r <= 1'b1;
      iack_sel_n_r <= 1'b1;
      berr_n_r <= 1'b1;
    end else begin
      case (ik_r)
        IK_IDLE: begin
          if (iack_hit && link.irq_n) begin
            ik_r <= IK_BERR;
            berr_n_r <= 1'b0; // [R21]
          end else if (iack_hit && AUTOVEC) begin
            ik_r <= IK_AVEC;
            avec_n_r <= 1'b0; // [R16] [R14]
          end else if (iack_hit) begin
            ik_r <= IK_SEL;
            iack_sel_n_r <= 1'b0; // [R17] [R14]
          end
        end
        IK_AVEC, IK_SEL, IK_BERR: begin
          if (as_n_s) begin
            ik_r <= IK_IDLE;
            avec_n_r <= 1'b1;
            iack_sel_n_r <= 1'b1;
            berr_n_r <= 1'b1;
          end
        end
        default: begin
          ik_r <= IK_IDLE;
          avec_n_r <= 1'b1;
          iack_sel_n_r <= 1'b1;
          berr_n_r <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ==== pe_link_assertions.sv ====
// Purpose: Checks on the engine-to-glue link
// Assumes: One clock, clk_sys
// Notes: Mask is mirrored from link writes
`timescale 1ns/10ps
module pe_link_assertions
  import pe_glue_pkg::*;
(
  input wire logic clk_sys, // Clock
  input wire logic reset, // Reset
  input wire logic buffer_drive_enable, // Drive enable
  input wire logic granularity, // Granularity
  input wire logic irq_n, // Irq, low
  input wire logic [INT_W-1:0] eng_status, // Flags
  input wire logic eng_wr_stb, // Write strobe
  input wire logic eng_wr_sel, // Mask or ack
  input wire logic [INT_W-1:0] eng_wdata // Write data
);
  logic [INT_W-1:0] mask_r;
  logic msk_w;
  logic ack_w;
  assign msk_w = eng_wr_stb && eng_wr_sel == SEL_MASK;
  assign ack_w = eng_wr_stb && eng_wr_sel == SEL_ACK;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mask_r <= MASK_RESET;
    end else if (msk_w) begin
      mask_r <= eng_wdata;
    end
  end
  // ----
  // Link rules
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_mask_none;
    msk_w && eng_wdata == '0;
  endsequence
  sequence s_quiet_low;
    !irq_n && !eng_wr_stb;
  endsequence
  a_flags_sticky: assert property (!eng_wr_stb |=>
    ($past(eng_status) & ~eng_status) == '0) else $error("flag fell without ack");
  a_ack_keeps: assert property (ack_w |=>
    ($past(eng_status) & ~$past(eng_wdata) & ~eng_status) == '0) else $error("ack lost bit");
  a_irq_level: assert property (!$past(msk_w) |->
    irq_n == !(|(eng_status & mask_r))) else $error("irq level wrong");
  a_irq_hold: assert property (s_quiet_low |=> !irq_n)
    else $error("irq dropped");
  a_irq_rise: assert property ($rose(|(eng_status & mask_r)) && !$past(msk_w) |->
    $fell(irq_n)) else $error("irq missed");
  a_stb_pulse: assert property (eng_wr_stb |=> !eng_wr_stb [*2])
    else $error("strobe too long");
  a_reset_clean: assert property ($fell(reset) |->
    irq_n && eng_status == '0 && !buffer_drive_enable) else $error("reset state");
  a_mask_all: assert property (s_mask_none |=> ##1 irq_n)
    else $error("masked irq seen");
endmodule

// ==== pixel_engine_host_bus_glue_tb.sv ====
// Purpose: Testbench for engine end and host glue
// Assumes: APB master, model in integers
// Notes: Seed 78
`timescale 1ns/10ps
module pixel_engine_host_bus_glue_tb;
  import pe_glue_pkg::*;
  logic clk_sys = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = '0, int_events = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, plane_buf_en_r, pixel_buf_en_r, buf_dir_write_r;
  logic avec_n_r, iack_sel_n_r, berr_n_r, as_n = 1'b1;
  logic sw_signal = 1'b0, pick_detect = 1'b0, pick_enable = 1'b0, xfer_active = 1'b0;
  logic xfer_gran = 1'b0, system_write_line = 1'b0, data_dma_acknowledge = 1'b0;
  logic [2:0] fc = '0, addr_3_1 = '0, ipl_n_r;
  logic [3:0] addr_19_16 = '0, plane_active = '0, pixels_per_word_field = '0, cur_step_r;
  int error_cnt = 0, checks_done = 0, mode_m = 0, flags_m = 0, mask_m = 0, spur_m = 0, i;
  always #20 clk_sys = ~clk_sys;
  pe_link_if link ();
  pixel_engine_end u_pixel_engine_end (.clk_sys(clk_sys), .reset(reset), .link(link),
    .int_events(int_events), .sw_signal(sw_signal), .pick_detect(pick_detect),
    .pick_enable(pick_enable), .xfer_active(xfer_active), .xfer_gran(xfer_gran),
    .plane_active(plane_active), .pixels_per_word_field(pixels_per_word_field),
    .cur_step_r(cur_step_r));
  host_bus_glue u_host_bus_glue (.clk_sys(clk_sys), .reset(reset), .link(link), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .as_n(as_n), .fc(fc), .addr_19_16(addr_19_16),
    .addr_3_1(addr_3_1), .system_write_line(system_write_line),
    .data_dma_acknowledge(data_dma_acknowledge), .plane_buf_en_r(plane_buf_en_r),
    .pixel_buf_en_r(pixel_buf_en_r), .buf_dir_write_r(buf_dir_write_r), .ipl_n_r(ipl_n_r),
    .avec_n_r(avec_n_r), .iack_sel_n_r(iack_sel_n_r), .berr_n_r(berr_n_r));
  pe_link_assertions u_pe_link_assertions (.clk_sys(clk_sys), .reset(reset),
    .buffer_drive_enable(link.buffer_drive_enable), .granularity(link.granularity),
    .irq_n(link.irq_n), .eng_status(link.eng_status), .eng_wr_stb(link.eng_wr_stb),
    .eng_wr_sel(link.eng_wr_sel), .eng_wdata(link.eng_wdata));
  // ----
  // Tasks
  // ----
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
      error_cnt++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    chk("pready", 32'h1, {31'h0, pready});
    if (n == 20) tally_and_finish;
  endtask
  task automatic wait_resp(input logic [2:0] exp);
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys);
      if ({berr_n_r, iack_sel_n_r, avec_n_r} === exp) break;
    end
    chk("iack response", {29'h0, exp}, {29'h0, berr_n_r, iack_sel_n_r, avec_n_r});
    if (n == 20) tally_and_finish;
  endtask
  task automatic ev(input logic [8:0] b);
    @(posedge clk_sys);
    {sw_signal, int_events} <= b;
    @(posedge clk_sys);
    {sw_signal, int_events} <= '0;
    flags_m |= b;
  endtask
  function automatic logic [31:0] st(input int mis);
    return {28'h0, mis[0], spur_m[0], (flags_m & mask_m) != 0, mode_m[0]};
  endfunction
  initial begin
    i = $urandom(78);
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("outs", 32'h3F, {plane_buf_en_r, pixel_buf_en_r, buf_dir_write_r, ipl_n_r,
      avec_n_r, iack_sel_n_r, berr_n_r});
    apb(1'b0, OFS_STATUS, '0);
    chk("status", 32'h0, rd);
    chk("mapped", 32'h0, {31'h0, er});
    apb(1'b1, 8'h20, $urandom);
    chk("unmapped", 32'h1, {31'h0, er});
    $display("test reset done");
    xfer_active <= 1'b1;
    plane_active <= 4'h1 + 4'($urandom % 15);
    pixels_per_word_field <= 4'($urandom);
    for (i = 0; i < 4; i++) begin
      mode_m = i / 2;
      xfer_gran <= i[0];
      apb(mode_m[0], mode_m[0] ? OFS_MODE_SET : OFS_MODE_CLR, $urandom);
      repeat (3) @(posedge clk_sys);
      chk("enables", {30'h0, mode_m[0], !mode_m[0]}, {30'h0, pixel_buf_en_r, plane_buf_en_r});
      apb(1'b0, OFS_STATUS, '0);
      chk("status mode", st(i[0] ^ mode_m[0]), rd);
    end
    chk("step", {28'h0, pixels_per_word_field}, {28'h0, cur_step_r});
    xfer_active <= 1'b0;
    for (i = 0; i < 4; i++) begin
      {data_dma_acknowledge, system_write_line} <= i[1:0];
      repeat (4) @(posedge clk_sys);
      chk("dir", 32'(i[0] ^ i[1]), {31'h0, buf_dir_write_r});
    end
    $display("test buffers done");
    apb(1'b1, OFS_ENG_MASK, 32'h1FF);
    mask_m = 'h1FF;
    pick_detect <= 1'b1;
    ev(9'h0);
    pick_detect <= 1'b0;
    for (i = 0; i < 9; i++) begin
      ev(9'h1 << i);
      apb(1'b0, OFS_ENG_STATUS, '0);
      chk("flags", 32'(flags_m), rd);
      chk("ipl", 32'h3, {29'h0, ipl_n_r});
      apb(1'b1, OFS_ENG_ACK, 32'(flags_m));
      flags_m = 0;
      repeat (3) @(posedge clk_sys);
      chk("ipl idle", 32'h7, {29'h0, ipl_n_r});
    end
    ev(9'h005);
    apb(1'b0, OFS_ENG_STATUS, '0);
    {pick_enable, pick_detect} <= 2'b11;
    ev(9'h000);
    pick_detect <= 1'b0;
    apb(1'b1, OFS_ENG_ACK, 32'h5);
    flags_m = 'h100;
    apb(1'b0, OFS_ENG_STATUS, '0);
    chk("kept", 32'(flags_m), rd);
    chk("ipl kept", 32'h3, {29'h0, ipl_n_r});
    $display("test interrupts done");
    {as_n, fc, addr_19_16, addr_3_1} <= {1'b0, IACK_FC, IACK_CODE, 3'h4};
    wait_resp(3'b110);
    as_n <= 1'b1;
    wait_resp(3'b111);
    {as_n, fc} <= {1'b0, 3'h6};
    repeat (8) @(posedge clk_sys);
    chk("wrong code", 32'h7, {29'h0, berr_n_r, iack_sel_n_r, avec_n_r});
    {as_n, fc} <= {1'b1, IACK_FC};
    apb(1'b1, OFS_ENG_ACK, 32'h1FF);
    flags_m = 0;
    as_n <= 1'b0;
    wait_resp(3'b011);
    as_n <= 1'b1;
    wait_resp(3'b111);
    spur_m = 1;
    apb(1'b0, OFS_STATUS, '0);
    chk("spurious", st(0), rd);
    apb(1'b1, OFS_STATUS, 32'h4);
    spur_m = 0;
    apb(1'b0, OFS_STATUS, '0);
    chk("spurious clr", st(0), rd);
    apb(1'b1, OFS_ENG_MASK, 32'h0);
    repeat (3) @(posedge clk_sys);
    $display("test iack done");
    tally_and_finish;
  end
endmodule
